// *** bench/qss_host.sv ***
// Host-side serial master model
`timescale 1ns/10ps
module qss_host (
	input wire clock, // System clock
	input wire so, // Device serial out
	output reg sclk, // Serial clock
	output reg cs_n, // Select, active low
	output reg si // Serial data
);
	integer i;
	initial begin
		sclk = 1'b0;
		cs_n = 1'b1;
		si = 1'b0;
	end
	// Frame of n bits at 400 ns per bit; clock is low at both select edges
	task xfer(input [15:0] tx, input integer n, output [15:0] rx);
		begin
			rx = 16'h0000;
			@(posedge clock) cs_n <= 1'b0;
			repeat (8) @(posedge clock);
			for (i = 0; i < n; i = i + 1) begin
				sclk <= 1'b1;
				si <= tx[15 - i];
				repeat (4) @(posedge clock);
				sclk <= 1'b0;
				repeat (3) @(posedge clock);
				@(negedge clock) rx = {rx[14:0], so};
				@(posedge clock);
			end
			repeat (4) @(posedge clock);
			cs_n <= 1'b1;
			si <= ~si; // Released line must not keep its last bit
			repeat (12) @(posedge clock);
		end
	endtask
endmodule

// *** bench/qss_top_assertions.sv ***
// Port-level assertions for the quad switch serial and mode block
`timescale 1ns/10ps
module qss_top_assertions #(
	parameter CH = 4
) (
	input wire clock, // Clock
	input wire srst, // Reset
	input wire sclk, // Serial clock
	input wire cs_n, // Select
	input wire so, // Serial out
	input wire so_oe, // Out enable
	input wire wake, // Wake
	input wire reset_n, // Device reset
	input wire failsafe_select_in, // Fail-safe pin
	input wire [1:0] failsafe_resistor, // Resistor code
	input wire [CH-1:0] fault_detect, // Faults
	input wire [CH-1:0] high_side_outputs, // Drives
	input wire fault_flag_n_oe, // Flag pulldown
	input wire current_sense_out_oe, // Sense enable
	input wire [1:0] mode // Mode
);
	reg [3:0] since_ev;
	default clocking
		@(posedge clock);
	endclocking
	default disable iff (srst);
	// Cycles since the last pin event that may move the serial output
	always @(posedge clock) begin
		if (srst || $rose(sclk) || $fell(cs_n) || $rose(cs_n))
			since_ev <= 4'h0;
		else if (since_ev != 4'hF)
			since_ev <= since_ev + 4'h1;
	end
	cs_high_release_a: assert property (cs_n [*8] |-> !so_oe)
		else $error("so driven while deselected");
	cs_low_drive_a: assert property (!cs_n [*8] |-> so_oe)
		else $error("so not driven in frame");
	so_timing_a: assert property ($changed(so) && so_oe && $past(so_oe) |-> since_ev < 4'h8)
		else $error("so moved without clock rise");
	sleep_off_a: assert property (mode == 2'd0 && $past(mode) == 2'd0 |-> high_side_outputs == {CH{1'b0}})
		else $error("output on in sleep");
	sense_sleep_a: assert property (mode == 2'd0 && $past(mode) == 2'd0 |-> !current_sense_out_oe)
		else $error("sense on in sleep");
	fault_flag_a: assert property (mode != 2'd0 && fault_detect != {CH{1'b0}} |-> ##[1:2] fault_flag_n_oe)
		else $error("fault flag not pulled");
	fault_off_a: assert property (!(|(fault_detect & $past(fault_detect) & $past(fault_detect, 2) & high_side_outputs)))
		else $error("faulted channel on");
	fs_pattern_a: assert property (mode == 2'd3 && $past(mode, 2) == 2'd3 && failsafe_resistor == 2'h2 &&
		$past(failsafe_resistor, 2) == 2'h2 |-> high_side_outputs[3:0] == 4'h5)
		else $error("fail-safe pattern wrong");
	sleep_entry_a: assert property ((!wake && !reset_n) [*8] |-> mode == 2'd0)
		else $error("no sleep");
	ground_no_fs_a: assert property (!failsafe_select_in [*8] |-> mode != 2'd3)
		else $error("fail-safe while grounded");
endmodule
bind qss_top qss_top_assertions #(.CH(CH)) qss_top_assertions_inst (.clock(clock), .srst(srst), .sclk(sclk),
	.cs_n(cs_n), .so(so), .so_oe(so_oe), .wake(wake), .reset_n(reset_n), .failsafe_select_in(failsafe_select_in),
	.failsafe_resistor(failsafe_resistor), .fault_detect(fault_detect), .high_side_outputs(high_side_outputs),
	.fault_flag_n_oe(fault_flag_n_oe), .current_sense_out_oe(current_sense_out_oe), .mode(mode));

// *** bench/tb.sv ***
// Self-checking bench for the quad switch serial and mode block
`timescale 1ns/10ps
module tb;
	reg clock, srst, wake, reset_n, fsel, ka;
	reg [3:0] din, fdet;
	reg [1:0] fres;
	reg [15:0] rx;
	wire sclk, cs_n, si, so, so_oe, flag_oe, sns_oe;
	wire [3:0] hs;
	wire [1:0] sns_sel, mode;
	integer bad_count, check_count, cyc;
	qss_top #(.WDTO0(32'd3000)) qss_top_inst (.clock(clock), .srst(srst), .sclk(sclk), .cs_n(cs_n), .si(si),
		.so(so), .so_oe(so_oe), .direct_inputs(din), .wake(wake), .reset_n(reset_n), .failsafe_select_in(fsel),
		.failsafe_resistor(fres), .fault_detect(fdet), .high_side_outputs(hs), .fault_flag_n_oe(flag_oe),
		.current_sense_sel(sns_sel), .current_sense_out_oe(sns_oe), .mode(mode));
	qss_host qss_host_inst (.clock(clock), .so(so), .sclk(sclk), .cs_n(cs_n), .si(si));
	initial begin
		clock = 1'b0;
		forever #25 clock = ~clock;
	end
	task complete_run;
		begin
			$display("checks %0d mismatches %0d", check_count, bad_count);
			if (bad_count == 0 && check_count > 0)
				$display("== PASSED ==");
			else
				$display("== FAILED ==");
			$finish;
		end
	endtask
	task check(input [15:0] got, input [15:0] exp);
		begin
			check_count = check_count + 1;
			if (got !== exp) begin
				bad_count = bad_count + 1;
				$display("mismatch at %0t: got %h expected %h", $time, got, exp);
			end
		end
	endtask
	task cycles(input integer n);
		repeat (n) @(posedge clock);
	endtask
	task send(input [4:0] a, input [9:0] d);
		begin
			ka = ~ka;
			qss_host_inst.xfer({ka, a, d}, 16, rx);
		end
	endtask
	task combo(input [9:0] cfg, input [9:0] on, input [3:0] exp);
		begin
			send(5'h02, cfg);
			send(5'h01, on);
			cycles(10);
			check(hs, exp);
		end
	endtask
	always @(posedge clock) begin
		cyc <= cyc + 1;
		if (cyc == 30000) begin
			bad_count = bad_count + 1;
			complete_run;
		end
	end
	initial begin
		{srst, wake, reset_n, fsel, ka, din, fdet, fres} = 15'h7802;
		{bad_count, check_count, cyc} = 0;
		cycles(2);
		srst <= 1'b0;
		cycles(1);
		check({mode, hs}, 16'h0000);
		cycles(20);
		check(mode, 16'h0001);
		din <= 4'h5;
		combo(10'h0FF, 10'h00F, 4'hF);
		combo(10'h000, 10'h000, 4'h5);
		combo(10'h055, 10'h00A, 4'hF);
		combo(10'h0AA, 10'h003, 4'h1);
		qss_host_inst.xfer({~ka, 5'h01, 10'h00F}, 15, rx);
		check(hs, 16'h0001);
		send(5'h1F, 10'h3FF);
		check(hs, 16'h0001);
		check(rx & 16'h00F4, 16'h0010);
		send(5'h03, 10'h006);
		check({sns_oe, sns_sel}, 16'h0006);
		send(5'h03, 10'h000);
		check(sns_oe, 16'h0000);
		fdet <= 4'h1;
		cycles(8);
		check({flag_oe, mode, hs}, 16'h0060);
		fdet <= 4'h0;
		cycles(8);
		send(5'h00, 10'h000);
		check(rx[15:12], 16'h0001);
		send(5'h00, 10'h000);
		check(rx[15:12], 16'h0000);
		{wake, reset_n} <= 2'b00;
		cycles(10);
		check({mode, hs, sns_oe}, 16'h0000);
		{wake, reset_n, din} <= 6'h3A;
		repeat (20) send(5'h00, 10'h000);
		check({mode, hs}, 16'h001A);
		cycles(3100);
		check({mode, hs}, 16'h0035);
		send(5'h01, 10'h00F);
		check(hs, 16'h0005);
		check(rx[2], 16'h0001);
		fres <= 2'h1;
		cycles(8);
		check(hs, 16'h0001);
		fres <= 2'h0;
		cycles(8);
		check(hs, 16'h0000);
		fres <= 2'h2;
		{wake, reset_n} <= 2'b00;
		cycles(10);
		check(mode, 16'h0000);
		{wake, reset_n} <= 2'b11;
		cycles(3100);
		check(mode, 16'h0003);
		fsel <= 1'b0;
		cycles(10);
		check(mode, 16'h0001);
		reset_n <= 1'b0;
		cycles(10);
		reset_n <= 1'b1;
		cycles(3100);
		check(mode, 16'h0001);
		complete_run;
	end
endmodule

// *** verilog/qss_defs.vh ***
// Constants for the quad switch serial control and mode logic
`ifndef QSS_DEFS_VH
`define QSS_DEFS_VH
`define QSS_FRAME_BITS 16
`define QSS_CNT_W 5
`define QSS_ADDR_HI 14
`define QSS_ADDR_LO 10
`define QSS_KEEPALIVE_BIT 15
`define QSS_ADDR_OUTCTL 5'h01
`define QSS_ADDR_INCFG 5'h02
`define QSS_ADDR_SENSE 5'h03
`define QSS_ADDR_WDOG 5'h04
`define QSS_WD_SEL_HI 1
`define QSS_WD_SEL_LO 0
`define QSS_SENSE_EN_BIT 2
`define QSS_FS_ALL_OFF 2'h0
`define QSS_FS_HS0 2'h1
`define QSS_FS_HS0_HS2 2'h2
`define QSS_FS_DISABLED 2'h3
`define QSS_WATCHDOG_EXPIRED_FLAG_MS0 558
`define QSS_WATCHDOG_EXPIRED_FLAG_MS1 279
`define QSS_WATCHDOG_EXPIRED_FLAG_MS2 2250
`define QSS_WATCHDOG_EXPIRED_FLAG_MS3 1125
`define QSS_CLK_KHZ 20000
`define QSS_WATCHDOG_EXPIRED_FLAG_BIT 2
`endif

// *** verilog/qss_sync.v ***
// Three-stage input synchroniser with agreement filter
`timescale 1ns/10ps
module qss_sync #(
	parameter W = 1
) (
	input wire clock, // System clock
	input wire srst, // Synchronous reset
	input wire [W-1:0] async_in, // Inputs from pins
	output reg [W-1:0] sync_out // Filtered level
);
	reg [W-1:0] s1;
	reg [W-1:0] s2;
	reg [W-1:0] s3;
	genvar i;
	always @(posedge clock) begin
		if (srst) begin
			s1 <= {W{1'b0}};
			s2 <= {W{1'b0}};
			s3 <= {W{1'b0}};
		end else begin
			s1 <= async_in;
			s2 <= s1;
			s3 <= s2;
		end
	end
	generate
		for (i = 0; i < W; i = i + 1) begin : g_bit
			always @(posedge clock) begin
				if (srst)
					sync_out[i] <= 1'b0;
				else if (s2[i] == s3[i])
					sync_out[i] <= s3[i];
			end
		end
	endgenerate
endmodule

// *** verilog/qss_top.v ***
// Serial control port and mode logic of a four-channel high-side switch
`timescale 1ns/10ps
`include "qss_defs.vh"
module qss_top #(
	parameter CH = 4,
	parameter [31:0] WDTO0 = `QSS_WATCHDOG_EXPIRED_FLAG_MS0 * `QSS_CLK_KHZ,
	parameter [31:0] WDTO1 = `QSS_WATCHDOG_EXPIRED_FLAG_MS1 * `QSS_CLK_KHZ,
	parameter [31:0] WDTO2 = `QSS_WATCHDOG_EXPIRED_FLAG_MS2 * `QSS_CLK_KHZ,
	parameter [31:0] WDTO3 = `QSS_WATCHDOG_EXPIRED_FLAG_MS3 * `QSS_CLK_KHZ
) (
	input wire clock, // 20 MHz system clock
	input wire srst, // Synchronous reset, active high
	input wire sclk, // Serial clock pin
	input wire cs_n, // Chip select pin, active low
	input wire si, // Serial data in
	output reg so, // Serial data out
	output reg so_oe, // Serial out drive enable
	input wire [CH-1:0] direct_inputs, // Direct channel inputs
	input wire wake, // Wake pin
	input wire reset_n, // Device reset pin, active low
	input wire failsafe_select_in, // Fail-safe pin grounded reads zero
	input wire [1:0] failsafe_resistor, // Decoded resistor setting
	input wire [CH-1:0] fault_detect, // Per-channel fault conditions
	output reg [CH-1:0] high_side_outputs, // Channel drive
	output reg fault_flag_n_oe, // Open-drain fault pulldown enable
	output reg [1:0] current_sense_sel, // Sensed channel
	output reg current_sense_out_oe, // Sense output enable
	output reg [1:0] mode // 0 sleep,1 normal,2 fault,3 fail-safe
);
	localparam ST_SLEEP = 4'h1;
	localparam ST_NORMAL = 4'h2;
	localparam ST_FAULT = 4'h4;
	localparam ST_FSAFE = 4'h8;
	wire [5+CH-1:0] pin_raw;
	wire [5+CH-1:0] pin_sync;
	wire sclk_s;
	wire cs_s;
	wire si_s;
	wire wake_s;
	wire rstn_s;
	wire [CH-1:0] din_s;
	reg sclk_d;
	reg cs_d;
	reg wake_d;
	reg rstn_d;
	reg fsi_d;
	reg [15:0] shift_in;
	reg [15:0] shift_out;
	reg [`QSS_CNT_W-1:0] fall_cnt;
	reg [CH-1:0] cfg_on;
	reg [2*CH-1:0] cfg_incomb;
	reg [2:0] cfg_sense;
	reg [1:0] cfg_wd;
	reg keepalive_toggle;
	reg [CH-1:0] fault_latch;
	reg [31:0] wd_cnt;
	reg wd_run;
	reg [3:0] state;
	reg [3:0] next_state;
	reg [31:0] wd_limit;
	reg [CH-1:0] next_hs;
	reg [1:0] next_mode;
	wire sclk_rise;
	wire sclk_fall;
	wire cs_fall;
	wire cs_rise;
	wire [4:0] addr;
	wire [15:0] status_word;
	wire fsi_s;
	wire fs_enabled;
	wire fail_exit;
	integer k;

	// Select enters inverted so the synchroniser's cleared state is the idle level, giving no false edge after reset
	assign pin_raw = {{(CH-1){1'b0}}, failsafe_select_in, reset_n, wake, si, ~cs_n, sclk};
	qss_sync #(.W(6)) u_sync (
		.clock(clock),
		.srst(srst),
		.async_in(pin_raw[5:0]),
		.sync_out(pin_sync[5:0])
	);
	qss_sync #(.W(CH)) u_sync_din (
		.clock(clock),
		.srst(srst),
		.async_in(direct_inputs),
		.sync_out(din_s)
	);
	assign pin_sync[5+CH-1:6] = {(CH-1){1'b0}};
	assign sclk_s = pin_sync[0];
	assign cs_s = ~pin_sync[1];
	assign si_s = pin_sync[2];
	assign wake_s = pin_sync[3];
	assign rstn_s = pin_sync[4];
	assign fsi_s = pin_sync[5];

	assign sclk_rise = sclk_s & ~sclk_d & ~cs_s;
	assign sclk_fall = ~sclk_s & sclk_d & ~cs_s;
	assign cs_fall = ~cs_s & cs_d;
	assign cs_rise = cs_s & ~cs_d;
	assign addr = shift_in[`QSS_ADDR_HI:`QSS_ADDR_LO];
	assign fs_enabled = fsi_s;
	assign fail_exit = (wake_d & rstn_d & ~wake_s & ~rstn_s) | (fsi_d & ~fsi_s);
	// Status: fault latches, four zero bits, output state, expired flag
	assign status_word = {fault_latch, 4'h0, high_side_outputs, 1'b0,
		(state == ST_FSAFE), 2'h0};

	always @(posedge clock) begin
		if (srst) begin
			sclk_d <= 1'b0;
			cs_d <= 1'b1;
			wake_d <= 1'b0;
			rstn_d <= 1'b0;
			fsi_d <= 1'b0;
		end else begin
			sclk_d <= sclk_s;
			cs_d <= cs_s;
			wake_d <= wake_s;
			rstn_d <= rstn_s;
			fsi_d <= fsi_s;
		end
	end

	// Serial shifting and frame commit
	always @(posedge clock) begin
		if (srst) begin
			shift_in <= 16'h0000;
			shift_out <= 16'h0000;
			fall_cnt <= 5'h00;
			so <= 1'b0;
			so_oe <= 1'b0;
			cfg_on <= {CH{1'b0}};
			cfg_incomb <= {2*CH{1'b0}};
			cfg_sense <= 3'h0;
			cfg_wd <= 2'h0;
			keepalive_toggle <= 1'b0;
		end else begin
			so_oe <= ~cs_s;
			if (cs_fall) begin
				shift_out <= status_word;
				so <= status_word[15];
				fall_cnt <= 5'h00;
			end else if (sclk_rise && fall_cnt != 5'h00) begin
				so <= shift_out[15];
			end
			if (sclk_fall) begin
				shift_in <= {shift_in[14:0], si_s};
				shift_out <= {shift_out[14:0], 1'b0};
				if (fall_cnt != 5'h1F)
					fall_cnt <= fall_cnt + 5'h01;
			end
			if (!rstn_s || state == ST_SLEEP) begin
				cfg_on <= {CH{1'b0}};
				cfg_incomb <= {2*CH{1'b0}};
				cfg_sense <= 3'h0;
				cfg_wd <= 2'h0;
			end
			if (cs_rise && fall_cnt == `QSS_FRAME_BITS && rstn_s) begin
				keepalive_toggle <= shift_in[`QSS_KEEPALIVE_BIT];
				case (addr)
				`QSS_ADDR_OUTCTL: begin
					cfg_on <= shift_in[CH-1:0];
				end
				`QSS_ADDR_INCFG: begin
					cfg_incomb <= shift_in[2*CH-1:0];
				end
				`QSS_ADDR_SENSE: begin
					cfg_sense <= shift_in[2:0];
				end
				`QSS_ADDR_WDOG: begin
					cfg_wd <= shift_in[`QSS_WD_SEL_HI:`QSS_WD_SEL_LO];
				end
				default: begin
					cfg_wd <= cfg_wd;
				end
				endcase
			end
		end
	end

	// Fault latches: set wins over clear
	always @(posedge clock) begin
		if (srst || !rstn_s)
			fault_latch <= {CH{1'b0}};
		else if (cs_rise && fall_cnt == `QSS_FRAME_BITS)
			fault_latch <= fault_detect;
		else
			fault_latch <= fault_latch | fault_detect;
	end

	always @* begin
		case (cfg_wd)
		2'h0: wd_limit = WDTO0;
		2'h1: wd_limit = WDTO1;
		2'h2: wd_limit = WDTO2;
		default: wd_limit = WDTO3;
		endcase
	end

	// Watchdog
	always @(posedge clock) begin
		if (srst || !fs_enabled) begin
			wd_cnt <= 32'h0000_0000;
			wd_run <= 1'b0;
		end else if ((rstn_s & ~rstn_d) || (wake_s & ~wake_d)) begin
			// The pin rise is seen while state still reads sleep, so it must win
			wd_cnt <= 32'h0000_0000;
			wd_run <= 1'b1;
		end else if (state == ST_SLEEP) begin
			wd_cnt <= 32'h0000_0000;
			wd_run <= 1'b0;
		end else begin
			if (cs_rise && fall_cnt == `QSS_FRAME_BITS
				&& shift_in[`QSS_KEEPALIVE_BIT] != keepalive_toggle)
				wd_cnt <= 32'h0000_0000;
			else if (wd_run && state == ST_NORMAL && wd_cnt < wd_limit)
				wd_cnt <= wd_cnt + 32'h0000_0001;
		end
	end

	always @* begin
		next_state = state;
		case (state)
		ST_SLEEP: begin
			if (wake_s || rstn_s)
				next_state = ST_NORMAL;
		end
		ST_NORMAL, ST_FAULT: begin
			if (!wake_s && !rstn_s)
				next_state = ST_SLEEP;
			else if (fs_enabled && wd_run && wd_cnt >= wd_limit)
				next_state = ST_FSAFE;
			else if (fault_detect != {CH{1'b0}})
				next_state = ST_FAULT;
			else
				next_state = ST_NORMAL;
		end
		ST_FSAFE: begin
			if (fail_exit || !fs_enabled)
				next_state = (!wake_s && !rstn_s) ? ST_SLEEP : ST_NORMAL;
		end
		default: next_state = ST_SLEEP;
		endcase
	end

	always @* begin
		next_hs = {CH{1'b0}};
		next_mode = 2'h0;
		case (state)
		ST_FSAFE: begin
			next_mode = 2'h3;
			case (failsafe_resistor)
			`QSS_FS_HS0: next_hs[0] = 1'b1;
			`QSS_FS_HS0_HS2: begin
				next_hs[0] = 1'b1;
				next_hs[2] = 1'b1;
			end
			default: next_hs = {CH{1'b0}};
			endcase
		end
		ST_NORMAL, ST_FAULT: begin
			next_mode = (state == ST_FAULT) ? 2'h2 : 2'h1;
			for (k = 0; k < CH; k = k + 1) begin
				case (cfg_incomb[2*k +: 2])
				2'h0: next_hs[k] = din_s[k];
				2'h1: next_hs[k] = din_s[k] | cfg_on[k];
				2'h2: next_hs[k] = din_s[k] & cfg_on[k];
				default: next_hs[k] = cfg_on[k];
				endcase
				if (fault_detect[k])
					next_hs[k] = 1'b0;
			end
		end
		default: next_hs = {CH{1'b0}};
		endcase
	end

	always @(posedge clock) begin
		if (srst) begin
			state <= ST_SLEEP;
			high_side_outputs <= {CH{1'b0}};
			mode <= 2'h0;
			fault_flag_n_oe <= 1'b0;
			current_sense_sel <= 2'h0;
			current_sense_out_oe <= 1'b0;
		end else begin
			state <= next_state;
			high_side_outputs <= next_hs;
			mode <= next_mode;
			fault_flag_n_oe <= (fault_detect != {CH{1'b0}}) || (fault_latch != {CH{1'b0}});
			current_sense_sel <= cfg_sense[1:0];
			current_sense_out_oe <= cfg_sense[`QSS_SENSE_EN_BIT] && state != ST_SLEEP;
		end
	end
endmodule
